// ==== hw/tsa_cfg.svh ====
`ifndef TSA_CFG_SVH
`define TSA_CFG_SVH
// Summary of operation
// - Result kept as 16-bit signed value, one LSB is 1/16 degree.
// - Result reads as +85 degrees until the first conversion lands.
// - Each finished conversion is compared with upper and lower limit.
// - Only result bits 11 to 4 take part in the limit comparison.
// - Alarm set when result above upper or below lower limit.
// - Alarm re-evaluated on each conversion, cleared once inside limits.
// - Alarm search command is joined only while alarm is set.
// - Fixed 64-bit identity: family, 48-bit serial, checksum on top.
// - Scratchpad volatile; limits and configuration backed nonvolatile.
// - Bytes 0 and 1 are result low and high byte, read-only.
// - Bytes 2, 3, 4 are upper limit, lower limit, configuration.
// - Bytes 5 to 7 reserved, writes ignored, read as all ones.
// - Byte 8 is read-only checksum of bytes 0 to 7, kept current.
// - Write command stores three bytes into bytes 2, 3, 4 in order.
// - Read command sends scratchpad bytes from byte 0 upward.
// - Copy command stores limits and configuration nonvolatile.
// - At power-up nonvolatile values load into the scratchpad.
// - Recall reloads scratchpad; status reads 0 busy, 1 done.
// - Two configuration bits pick resolution, default both one.
// - Configuration bit 7 and bits 4 to 0 ignore writes, read ones.
// - Select 00 to 11 means 9 to 12 bits, 93.75 to 750 ms.
// - Low result bits forced to zero at reduced resolution.
// - Checksums use x^8+x^5+x^4+1, start at zero, LSB first.

// --------------------------------------------------------------
// Scratchpad byte offsets
// --------------------------------------------------------------
`define TSA_OFS_TEMP_LO 4'h0
`define TSA_OFS_TEMP_HI 4'h1
`define TSA_OFS_UPPER 4'h2
`define TSA_OFS_LOWER 4'h3
`define TSA_OFS_CONFIG 4'h4
`define TSA_OFS_CRC 4'h8

// --------------------------------------------------------------
// Function commands
// --------------------------------------------------------------
`define TSA_CMD_WRITE 8'h4e
`define TSA_CMD_READ 8'hbe
`define TSA_CMD_COPY 8'h48
`define TSA_CMD_RECALL 8'hb8
`define TSA_CMD_ALARM_SRCH 8'hec

// --------------------------------------------------------------
// Field layout and reset values
// --------------------------------------------------------------
`define TSA_TEMP_RESET 16'h0550
`define TSA_CMP_MSB 11
`define TSA_CMP_LSB 4
`define TSA_RES_MSB 6
`define TSA_RES_LSB 5
`define TSA_RES_RESET 2'h3
`define TSA_CFG_ONES 8'h9f
`define TSA_RSVD_BYTE 8'hff
`define TSA_MASK_9 16'hfff8
`define TSA_MASK_10 16'hfffc
`define TSA_MASK_11 16'hfffe
`define TSA_MASK_12 16'hffff
`define TSA_CRC_POLY 8'h8c
`define TSA_CRC_INIT 8'h00
`define TSA_ROM_BITS 56
`define TSA_SP_BITS 64
// Identity and factory values below are arbitrary
`define TSA_FAMILY 8'h5a
`define TSA_SERIAL 48'h0000_1234_5678
`define TSA_NV_UPPER_RESET 8'h7f
`define TSA_NV_LOWER_RESET 8'h80

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define TSA_CLK_KHZ 10000
`define TSA_T_WR_MS 10
`define TSA_TCONV12_MS 750
`define TSA_RECALL_CYCLES 17'h00010
`define TSA_FIFO_DEPTH 8

`endif

// ==== hw/tsa_core.sv ====
`timescale 1ns/1ps
`include "tsa_cfg.svh"
module tsa_core #(
  parameter int COPY_CYCLES = `TSA_T_WR_MS * `TSA_CLK_KHZ,
  parameter int CONV12_CYCLES = `TSA_TCONV12_MS * `TSA_CLK_KHZ
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input tsa_pkg::tsa_cmd_t cmd,
  input tsa_pkg::tsa_conv_t conv,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  output logic recall_done,
  output logic copy_busy,
  output logic search_join,
  output logic alarm_flag,
  output logic [1:0] resolution,
  output logic [22:0] conv_max_cycles,
  output logic [15:0] temp_result,
  output logic [63:0] rom_code
);
  import tsa_pkg::*;

  // ------------------------------------------------------------
  // Checksum over the low n bits, least significant bit first
  // ------------------------------------------------------------
  function automatic logic [7:0] crc_f(
    input logic [63:0] d,
    input int n
  );
    logic [7:0] c;
    logic fb;
    c = `TSA_CRC_INIT;
    for (int i = 0; i < 64; i++) begin
      if (i < n) begin
        fb = c[0] ^ d[i];
        c = c >> 1;
        if (fb) begin
          c = c ^ `TSA_CRC_POLY;
        end
      end
    end
    return c;
  endfunction : crc_f

  // ------------------------------------------------------------
  // Identity code
  // ------------------------------------------------------------
  localparam logic [55:0] ROM_LOW = {`TSA_SERIAL, `TSA_FAMILY};
  localparam logic [7:0] ROM_CRC = crc_f({8'h00, ROM_LOW},
    `TSA_ROM_BITS);

  // Fixed at elaboration; no state needed
  assign rom_code = {ROM_CRC, ROM_LOW};

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    tsa_state_t st;
    logic [15:0] temp;
    logic [7:0] upper;
    logic [7:0] lower;
    logic [1:0] res;
    logic [7:0] nv_upper;
    logic [7:0] nv_lower;
    logic [1:0] nv_res;
    logic alarm;
    logic join_srch;
    logic [3:0] idx;
    logic [16:0] cnt;
    logic [7:0] crc;
    logic [22:0] budget;
  } tsa_core_state_t;

  tsa_core_state_t s_r;
  tsa_core_state_t s_nxt;

  logic [7:0] cfg_byte;
  logic [63:0] sp64;
  logic [71:0] sp72;
  logic [7:0] push_data;
  logic push_valid;
  logic push_ready;
  logic fifo_flush;
  logic wr_take;
  logic [15:0] masked;
  logic signed [7:0] cmp_val;
  logic over_upper;
  logic under_lower;
  logic cmd_ok;

  // ------------------------------------------------------------
  // Scratchpad image
  // ------------------------------------------------------------
  // Only the select pair is stored; the other bits are tied high
  always_comb begin
    cfg_byte = `TSA_CFG_ONES;
    cfg_byte[`TSA_RES_MSB:`TSA_RES_LSB] = s_r.res;
  end

  assign sp64 = {`TSA_RSVD_BYTE, `TSA_RSVD_BYTE, `TSA_RSVD_BYTE,
                 cfg_byte, s_r.lower, s_r.upper,
                 s_r.temp};
  assign sp72 = {s_r.crc, sp64};
  assign push_data = sp72[{s_r.idx, 3'b000} +: 8];

  // ------------------------------------------------------------
  // Alarm comparison
  // ------------------------------------------------------------
  // Low bits below the chosen resolution are forced to zero as each
  // result is stored; a result already held keeps them until the next one
  always_comb begin
    unique case (s_r.res)
      2'h0: masked = conv.result & `TSA_MASK_9;
      2'h1: masked = conv.result & `TSA_MASK_10;
      2'h2: masked = conv.result & `TSA_MASK_11;
      default: masked = conv.result & `TSA_MASK_12;
    endcase
  end

  assign cmp_val = $signed(masked[`TSA_CMP_MSB:`TSA_CMP_LSB]);
  assign over_upper = cmp_val > $signed(s_r.upper);
  assign under_lower = cmp_val < $signed(s_r.lower);

  // ------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------
  assign wr_ready = clk_en && (s_r.st == TSA_ST_WRITE);
  assign wr_take = wr_valid && wr_ready;
  assign push_valid = (s_r.st == TSA_ST_READ);
  assign cmd_ok = cmd.valid && (s_r.st != TSA_ST_COPY);
  // A fresh read must not deliver bytes left from an aborted one
  assign fifo_flush = cmd_ok && (cmd.code == `TSA_CMD_READ);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.crc = crc_f(sp64, `TSA_SP_BITS);

    unique case (s_r.res)
      2'h0: s_nxt.budget = 23'(CONV12_CYCLES >> 3);
      2'h1: s_nxt.budget = 23'(CONV12_CYCLES >> 2);
      2'h2: s_nxt.budget = 23'(CONV12_CYCLES >> 1);
      default: s_nxt.budget = 23'(CONV12_CYCLES);
    endcase

    if (conv.valid) begin
      s_nxt.temp = masked;
      s_nxt.alarm = over_upper || under_lower;
    end

    unique case (s_r.st)
      TSA_ST_IDLE: begin
        s_nxt.idx = `TSA_OFS_TEMP_LO;
      end
      TSA_ST_READ: begin
        if (push_ready) begin
          if (s_r.idx == `TSA_OFS_CRC) begin
            s_nxt.st = TSA_ST_IDLE;
          end else begin
            s_nxt.idx = s_r.idx + 4'h1;
          end
        end
      end
      TSA_ST_WRITE: begin
        if (wr_take) begin
          unique case (s_r.idx)
            `TSA_OFS_UPPER: s_nxt.upper = wr_data;
            `TSA_OFS_LOWER: s_nxt.lower = wr_data;
            default: begin
              s_nxt.res = wr_data[`TSA_RES_MSB:`TSA_RES_LSB];
            end
          endcase
          if (s_r.idx == `TSA_OFS_CONFIG) begin
            s_nxt.st = TSA_ST_IDLE;
          end else begin
            s_nxt.idx = s_r.idx + 4'h1;
          end
        end
      end
      TSA_ST_COPY: begin
        // Store is committed at the end of the write time
        if (s_r.cnt == 17'(COPY_CYCLES - 1)) begin
          s_nxt.nv_upper = s_r.upper;
          s_nxt.nv_lower = s_r.lower;
          s_nxt.nv_res = s_r.res;
          s_nxt.st = TSA_ST_IDLE;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 17'h00001;
        end
      end
      TSA_ST_RECALL: begin
        if (s_r.cnt == `TSA_RECALL_CYCLES - 17'h00001) begin
          s_nxt.upper = s_r.nv_upper;
          s_nxt.lower = s_r.nv_lower;
          s_nxt.res = s_r.nv_res;
          s_nxt.st = TSA_ST_IDLE;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 17'h00001;
        end
      end
      default: begin
        s_nxt.st = TSA_ST_IDLE;
      end
    endcase

    // A new command ends any read or write still under way; the
    // copy runs to completion because its store cannot be torn
    if (cmd_ok) begin
      s_nxt.join_srch = 1'b0;
      s_nxt.cnt = '0;
      unique case (cmd.code)
        `TSA_CMD_WRITE: begin
          s_nxt.st = TSA_ST_WRITE;
          s_nxt.idx = `TSA_OFS_UPPER;
        end
        `TSA_CMD_READ: begin
          s_nxt.st = TSA_ST_READ;
          s_nxt.idx = `TSA_OFS_TEMP_LO;
        end
        `TSA_CMD_COPY: begin
          s_nxt.st = TSA_ST_COPY;
        end
        `TSA_CMD_RECALL: begin
          s_nxt.st = TSA_ST_RECALL;
        end
        `TSA_CMD_ALARM_SRCH: begin
          s_nxt.st = TSA_ST_IDLE;
          s_nxt.join_srch = s_r.alarm;
        end
        default: begin
          s_nxt.st = TSA_ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Nonvolatile copies take factory values on reset; a real part
  // keeps them over power loss, which this model cannot show
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_r.st <= TSA_ST_RECALL;
      s_r.temp <= `TSA_TEMP_RESET;
      s_r.upper <= `TSA_NV_UPPER_RESET;
      s_r.lower <= `TSA_NV_LOWER_RESET;
      s_r.res <= `TSA_RES_RESET;
      s_r.nv_upper <= `TSA_NV_UPPER_RESET;
      s_r.nv_lower <= `TSA_NV_LOWER_RESET;
      s_r.nv_res <= `TSA_RES_RESET;
      s_r.alarm <= 1'b0;
      s_r.join_srch <= 1'b0;
      s_r.idx <= `TSA_OFS_TEMP_LO;
      s_r.cnt <= '0;
      s_r.crc <= `TSA_CRC_INIT;
      s_r.budget <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read path buffer
  // ------------------------------------------------------------
  tsa_fifo #(
    .W(8),
    .D(`TSA_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .flush(fifo_flush),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(rd_valid),
    .out_data(rd_data),
    .out_ready(rd_ready)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign recall_done = (s_r.st != TSA_ST_RECALL);
  assign copy_busy = (s_r.st == TSA_ST_COPY);
  assign search_join = s_r.join_srch;
  assign alarm_flag = s_r.alarm;
  assign resolution = s_r.res;
  assign conv_max_cycles = s_r.budget;
  assign temp_result = s_r.temp;
endmodule : tsa_core

// ==== hw/tsa_fifo.sv ====
`timescale 1ns/1ps
module tsa_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  import tsa_pkg::*;

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tsa_fifo_state_t;

  tsa_fifo_state_t s_r;
  tsa_fifo_state_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = clk_en && (s_r.cnt != (AW+1)'(D));
  assign out_valid = clk_en && (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end
endmodule : tsa_fifo

// ==== hw/tsa_pkg.sv ====
package tsa_pkg;
  // ------------------------------------------------------------
  // Types shared by the core and its neighbours
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    TSA_ST_IDLE = 5'b00001,
    TSA_ST_READ = 5'b00010,
    TSA_ST_WRITE = 5'b00100,
    TSA_ST_COPY = 5'b01000,
    TSA_ST_RECALL = 5'b10000
  } tsa_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } tsa_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] result;
  } tsa_conv_t;
endpackage : tsa_pkg

// ==== sim/tsa_core_checker.sv ====
`timescale 1ns/1ps
`include "tsa_cfg.svh"
module tsa_core_checker #(
  parameter int COPY_CYCLES = 20,
  parameter int CONV12_CYCLES = 800
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input tsa_pkg::tsa_cmd_t cmd,
  input tsa_pkg::tsa_conv_t conv,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic recall_done,
  input wire logic copy_busy,
  input wire logic search_join,
  input wire logic alarm_flag,
  input wire logic [1:0] resolution,
  input wire logic [22:0] conv_max_cycles,
  input wire logic [15:0] temp_result,
  input wire logic [63:0] rom_code
);
  import tsa_pkg::*;
  import tsa_sim_pkg::*;
  logic take;
  logic cv;
  assign take = clk_en && cmd.valid && !copy_busy;
  assign cv = clk_en && conv.valid;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Sixteen busy cycles, then done; a command inside would abort it
  sequence s_recall_run;
    (!recall_done)[*8] ##1 (!recall_done)[*8] ##1 recall_done;
  endsequence
  sequence s_first_byte;
    ##1 rd_valid && rd_data == 8'($past(temp_result, 2));
  endsequence
  a_reset_values: assert property ($rose(resetn) |->
    temp_result == `TSA_TEMP_RESET && resolution == 2'h3) else $error("bad reset");
  a_conv_store: assert property (cv |=> temp_result ==
    ($past(conv.result) & (16'hffff << (3 - $past(resolution)))))
    else $error("result not stored");
  a_alarm_hold: assert property (!cv |=> $stable(alarm_flag))
    else $error("alarm moved without conversion");
  a_search_join: assert property (take &&
    cmd.code == `TSA_CMD_ALARM_SRCH |=> search_join == $past(alarm_flag))
    else $error("search join wrong");
  a_write_open: assert property (take &&
    cmd.code == `TSA_CMD_WRITE |=> wr_ready) else $error("write not open");
  a_read_first: assert property (take &&
    cmd.code == `TSA_CMD_READ |=> s_first_byte) else $error("byte0 wrong");
  a_recall_seq: assert property (take &&
    cmd.code == `TSA_CMD_RECALL |=> s_recall_run) else $error("recall status");
  a_copy_start: assert property (take &&
    cmd.code == `TSA_CMD_COPY |=> copy_busy[*8]) else $error("copy too short");
  a_res_cycles: assert property (clk_en |=> conv_max_cycles ==
    23'(CONV12_CYCLES >> (3 - $past(resolution)))) else $error("conv time");
  a_rom_crc: assert property (
    rom_code[63:56] == crc8({8'h00, rom_code[55:0]}, 56)) else $error("rom crc");
endmodule : tsa_core_checker

bind tsa_core tsa_core_checker #(
  .COPY_CYCLES(COPY_CYCLES), .CONV12_CYCLES(CONV12_CYCLES)
) i_chk (
  .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .cmd(cmd),
  .conv(conv), .wr_ready(wr_ready), .rd_valid(rd_valid),
  .rd_data(rd_data), .recall_done(recall_done), .copy_busy(copy_busy),
  .search_join(search_join), .alarm_flag(alarm_flag),
  .resolution(resolution), .conv_max_cycles(conv_max_cycles),
  .temp_result(temp_result), .rom_code(rom_code)
);

// ==== sim/tsa_core_test.sv ====
`timescale 1ns/1ps
`include "tsa_cfg.svh"
`define CHK(x, y) begin \
  samples_checked++; \
  if ((x) !== (y)) begin \
    n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (x), (y)); \
  end \
end

module tsa_core_test;
  import tsa_pkg::*;
  import tsa_sim_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic stall = 1'b0;
  tsa_cmd_t cmd = '0;
  tsa_conv_t conv = '0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_ready, rd_valid, rd_ready, recall_done, copy_busy;
  logic search_join, alarm_flag;
  logic [7:0] rd_data;
  logic [1:0] resolution;
  logic [22:0] conv_max_cycles;
  logic [15:0] temp_result;
  logic [63:0] rom_code;
  int n_errors = 0;
  int samples_checked = 0;
  logic [15:0] cv [5] = '{16'h0191, 16'h01a7, 16'hff6f, 16'hff5f, 16'h1000};
  logic al [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  always #50 ref_clk = ~ref_clk;

  tsa_core #(.COPY_CYCLES(20), .CONV12_CYCLES(800)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .cmd(cmd),
    .conv(conv), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_ready(rd_ready), .recall_done(recall_done),
    .copy_busy(copy_busy), .search_join(search_join),
    .alarm_flag(alarm_flag), .resolution(resolution),
    .conv_max_cycles(conv_max_cycles), .temp_result(temp_result),
    .rom_code(rom_code)
  );

  tsa_master_model i_master (
    .ref_clk(ref_clk), .stall(stall), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready(rd_ready)
  );

  task end_sim;
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #10;
  endtask : cyc

  task fail_to(input logic ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  endtask : fail_to

  // The extra cycle keeps two strobes from meeting in one time step
  task do_cmd(input logic [7:0] c);
    cmd = '{1'b1, c};
    cyc(1);
    cmd.valid = 1'b0;
    cyc(1);
  endtask : do_cmd

  task conv_in(input logic [15:0] v);
    conv = '{1'b1, v};
    cyc(1);
    conv.valid = 1'b0;
    cyc(1);
  endtask : conv_in

  task wait_done;
    int k;
    for (k = 0; k < 40 && !recall_done; k++) cyc(1);
    fail_to(recall_done);
  endtask : wait_done

  task wr3(input logic [23:0] v);
    int k;
    do_cmd(`TSA_CMD_WRITE);
    for (int i = 0; i < 3; i++) begin
      wr_valid = 1'b1;
      wr_data = v[8 * i +: 8];
      for (k = 0; k < 20 && !wr_ready; k++) cyc(1);
      fail_to(wr_ready);
      cyc(1);
    end
    wr_valid = 1'b0;
    cyc(1);
    `CHK(wr_ready, 1'b0)
  endtask : wr3

  // A held read fills the buffer, then the clock enable freezes it
  task rd9(input logic [63:0] e, input int hold);
    int b;
    int k;
    b = i_master.n;
    stall = hold > 0;
    do_cmd(`TSA_CMD_READ);
    if (hold > 0) begin
      cyc(hold);
      `CHK(rd_valid, 1'b1)
      `CHK(i_master.n, b)
      clk_en = 1'b0;
      cyc(1);
      `CHK(rd_valid, 1'b0)
      clk_en = 1'b1;
      stall = 1'b0;
    end
    for (k = 0; k < 60 && i_master.n < b + 9; k++) cyc(1);
    fail_to(i_master.n >= b + 9);
    for (int i = 0; i < 9; i++) begin
      `CHK(i_master.got[b + i], i < 8 ? e[8 * i +: 8] : crc8(e, 64))
    end
  endtask : rd9

  initial begin
    int k;
    cyc(12);
    resetn = 1'b1;
    `CHK(temp_result, 16'h0550)
    `CHK(resolution, 2'h3)
    `CHK(recall_done, 1'b0)
    `CHK(rom_code[55:0], {`TSA_SERIAL, `TSA_FAMILY})
    `CHK(rom_code[63:56], crc8({8'h00, `TSA_SERIAL, `TSA_FAMILY}, 56))
    wait_done();
    `CHK(conv_max_cycles, 23'h000320)
    rd9(64'hffff_ffff_807f_0550, 0);
    wr3(24'h00f619);
    `CHK(resolution, 2'h0)
    `CHK(conv_max_cycles, 23'h000064)
    rd9(64'hffff_ff9f_f619_0550, 10);
    for (int i = 0; i < 5; i++) begin
      conv_in(cv[i]);
      `CHK(temp_result, cv[i] & 16'hfff8)
      `CHK(alarm_flag, al[i])
      do_cmd(`TSA_CMD_ALARM_SRCH);
      `CHK(search_join, al[i])
    end
    rd9(64'hffff_ff9f_f619_1000, 0);
    do_cmd(`TSA_CMD_COPY);
    `CHK(copy_busy, 1'b1)
    do_cmd(`TSA_CMD_WRITE);
    `CHK(wr_ready, 1'b0)
    for (k = 0; k < 100 && copy_busy; k++) cyc(1);
    fail_to(!copy_busy);
    wr3(24'h602211);
    `CHK(resolution, 2'h3)
    do_cmd(`TSA_CMD_RECALL);
    `CHK(recall_done, 1'b0)
    wait_done();
    `CHK(resolution, 2'h0)
    rd9(64'hffff_ff9f_f619_1000, 0);
    end_sim();
  end
endmodule : tsa_core_test

// ==== sim/tsa_master_model.sv ====
`timescale 1ns/1ps
module tsa_master_model (
  input wire logic ref_clk,
  input wire logic stall,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_ready
);
  logic [7:0] got [128];
  int n = 0;
  // Stall gives the slow master; otherwise every byte is taken at once
  assign rd_ready = !stall;
  always @(posedge ref_clk) begin
    if (rd_valid && rd_ready) begin
      got[n] <= rd_data;
      n <= n + 1;
    end
  end
endmodule : tsa_master_model

// ==== sim/tsa_sim_pkg.sv ====
package tsa_sim_pkg;
  // Reflected form of x^8+x^5+x^4+1, register starts at zero, LSB first
  function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    end
    return c;
  endfunction : crc8
endpackage : tsa_sim_pkg
